// *** rtl/dspf_pkg.sv ***
// dspf_pkg: constants for the dual-slot power and fault logic.
// assumes a 250 MHz clk; all offsets are word indices on the plain register port.
package dspf_pkg;
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned DEBOUNCE_MS     = 5;
  localparam int unsigned DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned FTIMER_DEF_CYC  = 1000;
  localparam int          NSLOT           = 2;
  localparam int          AW              = 4;
  localparam int          DW              = 32;
  localparam logic [3:0]  OFS_STATE_A     = 4'h0;
  localparam logic [3:0]  OFS_STATE_B     = 4'h1;
  localparam logic [3:0]  OFS_COMMON      = 4'h2;
  localparam logic [3:0]  OFS_CTRL        = 4'h3;
  localparam logic [3:0]  OFS_FTIMER      = 4'h4;
  localparam logic [3:0]  OFS_IRQ_STAT    = 4'h5;
  localparam logic [3:0]  OFS_IRQ_MASK    = 4'h6;
  // slot state field positions
  localparam int ST_MAIN_ON   = 0;
  localparam int ST_AUX_ON    = 1;
  localparam int ST_MAIN_FLT  = 2;
  localparam int ST_AUX_FLT   = 3;
  localparam int ST_PGOOD     = 4;
  localparam int ST_FORCED    = 5;
  localparam int ST_PWR_OFF   = 6;
  localparam int ST_THERMAL   = 7;
  localparam logic [1:0]  CTRL_RST        = 2'h0;
  localparam logic [1:0]  IRQ_RST         = 2'h0;
  localparam logic [1:0]  MASK_RST        = 2'h3;
  typedef enum logic [1:0] {DSPF_IDLE, DSPF_TIMING, DSPF_TRIPPED} dspf_flt_t;
endpackage

// *** rtl/dspf_core.sv ***
// dspf_core: per-slot power enable, fault latch, force-on, debounce, status and interrupt.
// assumes analog comparator flags arrive asynchronously and are synchronised here.
// Behaviour
// - fault output low while any main or aux fault is latched
// - aux fault latched until aux power request goes low
// - main fault latched until main power request goes low
// - fault must persist the programmed timer interval before main power drops
// - power-good low only while all slot voltages are good
// - active force-on keeps the channel on despite a fault
// - force-on ignored while its inhibit bit is set
// - thermal shutdown overrides force-on
// - each slot state readable in a per-slot register
// - both inputs per slot debounced; levels in one common register
// - power-off status once all slot voltages fall below threshold after main off
// - debounce requires about 5 ms of stable input
// - interrupt low on unmasked fault, released when status cleared
// - aux output follows the aux request level, held off by a latched aux fault (unless forced) or by thermal shutdown
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dspf_core #(
  parameter int unsigned DEB_CYC = dspf_pkg::DEBOUNCE_CYC
) (
  input  wire  logic                     clk,
  input  wire  logic                     rst_b,
  input  wire  logic [dspf_pkg::NSLOT-1:0] main_power_request,
  input  wire  logic [dspf_pkg::NSLOT-1:0] aux_power_request,
  input  wire  logic [dspf_pkg::NSLOT-1:0] force_channel_on_n,
  input  wire  logic [dspf_pkg::NSLOT-1:0] slot_input_one,
  input  wire  logic [dspf_pkg::NSLOT-1:0] slot_input_two,
  input  wire  logic [dspf_pkg::NSLOT-1:0] main_fault_cond,
  input  wire  logic [dspf_pkg::NSLOT-1:0] aux_fault_cond,
  input  wire  logic [dspf_pkg::NSLOT-1:0] all_volt_good,
  input  wire  logic [dspf_pkg::NSLOT-1:0] all_volt_low,
  input  wire  logic [dspf_pkg::NSLOT-1:0] thermal_shut,
  input  wire  logic [dspf_pkg::AW-1:0]  reg_addr,
  input  wire  logic [dspf_pkg::DW-1:0]  reg_wdata,
  input  wire  logic                     reg_wr,
  input  wire  logic                     reg_rd,
  output var   logic [dspf_pkg::DW-1:0]  reg_rdata,
  output var   logic [dspf_pkg::NSLOT-1:0] main_power_on,
  output var   logic [dspf_pkg::NSLOT-1:0] aux_slot_output,
  output var   logic [dspf_pkg::NSLOT-1:0] slot_fault_n,
  output var   logic [dspf_pkg::NSLOT-1:0] slot_power_good_n,
  output var   logic                     irq_n
);
  import dspf_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int NIN = 10;
  // force-on is active low: its flops reset to the idle high level, so the
  // two cycles after reset do not look like a forced channel
  localparam logic [NIN*NSLOT-1:0] SYNC_IDLE =
    {{(2*NSLOT){1'b0}}, {NSLOT{1'b1}}, {(7*NSLOT){1'b0}}};
  logic [NIN*NSLOT-1:0] raw;
  logic [NIN*NSLOT-1:0] s1_q;
  logic [NIN*NSLOT-1:0] s2_q;
  assign raw = {main_power_request, aux_power_request, force_channel_on_n,
                slot_input_one, slot_input_two, main_fault_cond, aux_fault_cond,
                all_volt_good, all_volt_low, thermal_shut};
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic [NSLOT-1:0] on_s;
  logic [NSLOT-1:0] aux_s;
  logic [NSLOT-1:0] fon_n_s;
  logic [NSLOT-1:0] gi1_s;
  logic [NSLOT-1:0] gi2_s;
  logic [NSLOT-1:0] mf_s;
  logic [NSLOT-1:0] af_s;
  logic [NSLOT-1:0] vg_s;
  logic [NSLOT-1:0] vl_s;
  logic [NSLOT-1:0] th_s;
  assign {on_s, aux_s, fon_n_s, gi1_s, gi2_s, mf_s, af_s, vg_s, vl_s, th_s} = s2_q;

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  logic [NSLOT-1:0] inhibit_q;
  logic [15:0]      ftimer_q;
  logic [NSLOT-1:0] irq_stat_q;
  logic [NSLOT-1:0] irq_mask_q;
  logic [NSLOT-1:0] flt_now;
  logic [NSLOT-1:0] flt_prev_q;
  logic             wr_stat;
  assign wr_stat = reg_wr && (reg_addr == OFS_IRQ_STAT);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      inhibit_q  <= CTRL_RST;
      ftimer_q   <= 16'(FTIMER_DEF_CYC);
      irq_mask_q <= MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CTRL) begin
        inhibit_q <= reg_wdata[NSLOT-1:0];
      end else if (reg_addr == OFS_FTIMER) begin
        ftimer_q <= reg_wdata[15:0];
      end else if (reg_addr == OFS_IRQ_MASK) begin
        irq_mask_q <= reg_wdata[NSLOT-1:0];
      end
    end
  end

  // sticky fault events; a new fault beats a same-cycle write-one clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_stat_q <= IRQ_RST;
      flt_prev_q <= '0;
    end else begin
      flt_prev_q <= flt_now;
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? reg_wdata[NSLOT-1:0] : '0))
                    | (flt_now & ~flt_prev_q);
    end
  end

  // level output from a flop; it follows a clear one cycle later
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~|(irq_stat_q & irq_mask_q);
    end
  end

  // ---------------------------------------------------------------
  // per-slot logic
  // ---------------------------------------------------------------
  logic [7:0]       state_w [NSLOT];
  logic [NSLOT-1:0] gi1_q;
  logic [NSLOT-1:0] gi2_q;

  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    dspf_flt_t                    st_q;
    logic [15:0]                  tcnt_q;
    logic                         mflt_q;
    logic                         aflt_q;
    logic                         aon_q;
    logic                         off_q;
    logic                         forced;
    logic [$clog2(DEB_CYC+1)-1:0] d1_q;
    logic [$clog2(DEB_CYC+1)-1:0] d2_q;
    logic                         c1_q;
    logic                         c2_q;

    // -------------------------------------------------------------
    // force-on qualify
    // -------------------------------------------------------------
    // force-on counts only when not inhibited and no thermal trip
    assign forced = !fon_n_s[s] && !inhibit_q[s] && !th_s[s];

    // -------------------------------------------------------------
    // fault timer
    // -------------------------------------------------------------
    // condition must hold ftimer_q cycles; a gap restarts the count, so
    // a chattering fault never trips while the request stays high
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        st_q   <= DSPF_IDLE;
        tcnt_q <= '0;
      end else begin
        case (st_q)
          DSPF_IDLE: begin
            tcnt_q <= '0;
            if (mf_s[s] && on_s[s]) begin
              st_q <= DSPF_TIMING;
            end
          end
          DSPF_TIMING: begin
            if (!mf_s[s] || !on_s[s]) begin
              st_q <= DSPF_IDLE;
            end else if (tcnt_q + 16'h1 >= ftimer_q) begin
              st_q <= DSPF_TRIPPED;
            end else begin
              tcnt_q <= tcnt_q + 16'h1;
            end
          end
          default: begin
            if (!on_s[s]) begin
              st_q <= DSPF_IDLE;
            end
          end
        endcase
      end
    end
    assign mflt_q = (st_q == DSPF_TRIPPED);

    // -------------------------------------------------------------
    // aux fault latch
    // -------------------------------------------------------------
    // aux fault latches and clears only when the aux request drops
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        aflt_q <= 1'b0;
      end else if (!aux_s[s]) begin
        aflt_q <= 1'b0;
      end else if (af_s[s]) begin
        aflt_q <= 1'b1;
      end
    end
    assign aon_q = aux_s[s] && (!aflt_q || forced);

    // -------------------------------------------------------------
    // slot outputs
    // -------------------------------------------------------------
    // thermal wins over request and force; every pin leaves a flop
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        main_power_on[s]     <= 1'b0;
        aux_slot_output[s]   <= 1'b0;
        slot_fault_n[s]      <= 1'b1;
        slot_power_good_n[s] <= 1'b1;
      end else begin
        main_power_on[s]     <= !th_s[s] && ((on_s[s] && !mflt_q) || forced);
        aux_slot_output[s]   <= aon_q && !th_s[s];
        slot_fault_n[s]      <= !(mflt_q || aflt_q || th_s[s]);
        slot_power_good_n[s] <= !vg_s[s];
      end
    end

    // -------------------------------------------------------------
    // power-off status
    // -------------------------------------------------------------
    // power-off flag: main off and every rail under the low threshold
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        off_q <= 1'b0;
      end else begin
        off_q <= !main_power_on[s] && vl_s[s];
      end
    end

    // -------------------------------------------------------------
    // input debounce
    // -------------------------------------------------------------
    // debounce: accept a new level only after DEB_CYC stable cycles
    // any bounce shorter than that leaves the old level standing
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        d1_q <= '0;
        d2_q <= '0;
        c1_q <= 1'b0;
        c2_q <= 1'b0;
      end else begin
        if (gi1_s[s] == c1_q) begin
          d1_q <= '0;
        end else if (d1_q == ($bits(d1_q))'(DEB_CYC - 1)) begin
          d1_q <= '0;
          c1_q <= gi1_s[s];
        end else begin
          d1_q <= d1_q + 1'b1;
        end
        if (gi2_s[s] == c2_q) begin
          d2_q <= '0;
        end else if (d2_q == ($bits(d2_q))'(DEB_CYC - 1)) begin
          d2_q <= '0;
          c2_q <= gi2_s[s];
        end else begin
          d2_q <= d2_q + 1'b1;
        end
      end
    end
    assign gi1_q[s] = c1_q;
    assign gi2_q[s] = c2_q;

    assign flt_now[s] = mflt_q || aflt_q;
    // status word packs flags of this cycle only, never half updated
    assign state_w[s] = {th_s[s], off_q, !fon_n_s[s] && !inhibit_q[s], vg_s[s],
                         aflt_q, mflt_q, aux_slot_output[s], main_power_on[s]};
  end

  // ---------------------------------------------------------------
  // register read, data in the cycle after the strobe
  // ---------------------------------------------------------------
  // zero outside the read cycle so a late sample never sees stale state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == OFS_STATE_A) begin
        reg_rdata <= {24'h0, state_w[0]};
      end else if (reg_addr == OFS_STATE_B) begin
        reg_rdata <= {24'h0, state_w[1]};
      end else if (reg_addr == OFS_COMMON) begin
        reg_rdata <= {28'h0, gi2_q[1], gi1_q[1], gi2_q[0], gi1_q[0]};
      end else if (reg_addr == OFS_CTRL) begin
        reg_rdata <= {30'h0, inhibit_q};
      end else if (reg_addr == OFS_FTIMER) begin
        reg_rdata <= {16'h0, ftimer_q};
      end else if (reg_addr == OFS_IRQ_STAT) begin
        reg_rdata <= {30'h0, irq_stat_q};
      end else if (reg_addr == OFS_IRQ_MASK) begin
        reg_rdata <= {30'h0, irq_mask_q};
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule
`default_nettype wire

// *** tb/dspf_core_asserts.sv ***
// checker: port-level timing of the slot power and fault logic
// assumes slot a carries the traffic; inputs cross a two-flop sync
`timescale 1ns/1ps
`default_nettype none
module dspf_core_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [1:0]  main_power_request,
  input wire logic [1:0]  aux_power_request,
  input wire logic [1:0]  force_channel_on_n,
  input wire logic [1:0]  main_fault_cond,
  input wire logic [1:0]  aux_fault_cond,
  input wire logic [1:0]  all_volt_good,
  input wire logic [1:0]  thermal_shut,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0]  main_power_on,
  input wire logic [1:0]  aux_slot_output,
  input wire logic [1:0]  slot_fault_n,
  input wire logic [1:0]  slot_power_good_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // windows leave room for sync plus latch
  // ----------------------------------------
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside slot");
  a_aux_off: assert property (
    (!aux_power_request[0]) [*4] |-> !aux_slot_output[0]) else $error("aux on unasked");
  a_main_off: assert property (
    (!main_power_request[0] && force_channel_on_n[0]) [*5] |-> !main_power_on[0])
    else $error("main on unasked");
  a_main_on: assert property (
    (main_power_request[0] && force_channel_on_n[0] && slot_fault_n[0]
     && !main_fault_cond[0] && !thermal_shut[0]) [*6] |-> main_power_on[0])
    else $error("main dropped without fault");
  a_pgood_rel: assert property (
    (!all_volt_good[0]) [*5] |-> slot_power_good_n[0]) else $error("good while low");
  a_no_cause: assert property (
    (slot_fault_n[0] && !main_fault_cond[0] && !aux_fault_cond[0] && !thermal_shut[0])
    [*6] |=> slot_fault_n[0]) else $error("fault without cause");
  a_thermal_off: assert property (
    thermal_shut[0] [*6] |-> !main_power_on[0] && !slot_fault_n[0])
    else $error("thermal not obeyed");
  a_fault_clear: assert property (
    (!main_power_request[0] && !aux_power_request[0] && !thermal_shut[0]) [*6]
    |-> slot_fault_n[0]) else $error("fault kept after release");
  c_trip: cover property ($fell(slot_fault_n[0]));
  c_forced: cover property (main_power_on[0] && !force_channel_on_n[0]);
  c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind dspf_core dspf_core_chk u_chk (.clk, .rst_b, .main_power_request, .aux_power_request,
  .force_channel_on_n, .main_fault_cond, .aux_fault_cond, .all_volt_good, .thermal_shut,
  .reg_rd, .reg_rdata, .main_power_on, .aux_slot_output, .slot_fault_n, .slot_power_good_n);
`default_nettype wire

// *** tb/dspf_rail_model.sv ***
// rail model: slot voltages settle eight cycles after main power changes
// assumes a far shorter ramp than a real card, to keep runs brief
`timescale 1ns/1ps
`default_nettype none
module dspf_rail_model (
  input wire logic       clk,
  input wire logic [1:0] main_power_on,
  output var logic [1:0] all_volt_good,
  output var logic [1:0] all_volt_low
);
  logic [7:0] ha_q = 8'h0;
  logic [7:0] hb_q = 8'h0;
  always @(posedge clk) begin
    ha_q <= {ha_q[6:0], main_power_on[0]};
    hb_q <= {hb_q[6:0], main_power_on[1]};
  end
  assign all_volt_good = {&hb_q, &ha_q};
  assign all_volt_low  = {~|hb_q, ~|ha_q};
endmodule
`default_nettype wire

// *** tb/dual_slot_power_fault_logic_test.sv ***
// testbench: register and pin sequences against the slot logic
// assumes the short debounce parameter and a 20-cycle fault timer
`timescale 1ns/1ps
`default_nettype none
module dual_slot_power_fault_logic_test;
  import dspf_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq_n;
  logic [1:0] main_power_request = 2'h0, aux_power_request = 2'h0, slot_input_one = 2'h0;
  logic [1:0] force_channel_on_n = 2'h3, slot_input_two = 2'h0, main_fault_cond = 2'h0;
  logic [1:0] aux_fault_cond = 2'h0, thermal_shut = 2'h0, all_volt_good, all_volt_low;
  logic [1:0] main_power_on, aux_slot_output, slot_fault_n, slot_power_good_n;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  int errors = 0, samples_checked = 0, n;
  dspf_core #(.DEB_CYC(8)) dut (.*);
  dspf_rail_model rails (.clk, .main_power_on, .all_volt_good, .all_volt_low);
  initial forever #2 clk = ~clk;
  task cyc(input int k); repeat (k) @(posedge clk); #1; endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task summarize;
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    cyc(2); chk("rst_force", main_power_on, 2'h0);
    cyc(2);
    rd(OFS_CTRL); chk("ctrl", d, 32'h0);
    rd(OFS_FTIMER); chk("ftimer", d, 32'h3e8);
    rd(OFS_IRQ_MASK); chk("mask", d, 32'h3);
    rd(4'hf); chk("unmapped", d, 32'h0);
    wr(OFS_FTIMER, 32'h14);
    @(posedge clk) {main_power_request, aux_power_request} <= 4'h5;
    cyc(6); chk("aux_on", aux_slot_output, 2'h1);
    chk("main_on", main_power_on, 2'h1);
    cyc(14); chk("pgood", slot_power_good_n, 2'h2);
    @(posedge clk) main_fault_cond <= 2'h1;
    n = 0;
    while (slot_fault_n[0] !== 1'b0 && n < 60) begin cyc(1); n++; end
    if (n >= 60) begin errors++; summarize(); end
    chk("trip_time", 32'(n >= 20 && n <= 30), 32'h1);
    cyc(2); chk("fault", slot_fault_n, 2'h2);
    chk("main_off", main_power_on, 2'h0);
    chk("irq", irq_n, 1'b0);
    @(posedge clk) main_fault_cond <= 2'h0;
    cyc(20); rd(OFS_STATE_A); chk("st_flt", d[ST_MAIN_FLT], 1'b1);
    chk("st_off", d[ST_PWR_OFF], 1'b1);
    chk("pgood_off", slot_power_good_n, 2'h3);
    @(posedge clk) main_power_request <= 2'h0;
    cyc(6); chk("flt_clr", slot_fault_n, 2'h3);
    chk("irq_held", irq_n, 1'b0);
    wr(OFS_IRQ_STAT, 32'h1); cyc(3); chk("irq_clr", irq_n, 1'b1);
    wr(OFS_IRQ_MASK, 32'h2);
    @(posedge clk) aux_fault_cond <= 2'h1;
    cyc(6); chk("aux_flt", slot_fault_n, 2'h2);
    chk("masked", irq_n, 1'b1);
    @(posedge clk) aux_fault_cond <= 2'h0;
    cyc(6); chk("aux_held", slot_fault_n, 2'h2);
    wr(OFS_IRQ_MASK, 32'h3); cyc(3); chk("unmask", irq_n, 1'b0);
    wr(OFS_IRQ_STAT, 32'h1);
    @(posedge clk) aux_power_request <= 2'h0;
    cyc(6); chk("aux_clr", slot_fault_n, 2'h3);
    chk("irq_rel", irq_n, 1'b1);
    @(posedge clk) force_channel_on_n <= 2'h2;
    cyc(6); chk("forced", main_power_on, 2'h1);
    wr(OFS_CTRL, 32'h1); cyc(4); chk("inhibit", main_power_on, 2'h0);
    wr(OFS_CTRL, 32'h0); @(posedge clk) thermal_shut <= 2'h1;
    cyc(6); chk("thermal", {main_power_on, slot_fault_n}, 4'h2);
    @(posedge clk) {thermal_shut, force_channel_on_n} <= 4'h3;
    @(posedge clk) {slot_input_one, slot_input_two} <= 4'h9;
    cyc(3); rd(OFS_COMMON); chk("deb_early", d, 32'h0);
    cyc(20); rd(OFS_COMMON); chk("deb", d, 32'h6);
    @(posedge clk) slot_input_one <= 2'h3;
    cyc(3); @(posedge clk) slot_input_one <= 2'h2;
    cyc(20); rd(OFS_COMMON); chk("bounce", d, 32'h6);
    summarize();
  end
endmodule
`default_nettype wire
